// ### srf_pkg.sv
// Package for the processor status word block: offsets, field positions, reset values, carriers.
package srf_pkg;

  // ********************************************************************
  // Widths
  // ********************************************************************
  localparam int unsigned SRF_WORD_W   = 16;
  localparam int unsigned SRF_BUS_W    = 32;
  localparam int unsigned SRF_ADDR_W   = 32;
  localparam int unsigned SRF_IPL_W    = 3;
  localparam int unsigned SRF_LEVEL_W  = 4;

  // ********************************************************************
  // Register byte offsets
  // ********************************************************************
  localparam logic [7:0] SRF_OFS_STATUS   = 8'h00;
  localparam logic [7:0] SRF_OFS_CORECTL  = 8'h04;
  localparam logic [7:0] SRF_OFS_INTCTL1  = 8'h08;
  localparam int unsigned SRF_DEC_W       = 8;

  // ********************************************************************
  // Status word field positions
  // ********************************************************************
  localparam int unsigned SRF_B_CARRY     = 0;
  localparam int unsigned SRF_B_ZERO      = 1;
  localparam int unsigned SRF_B_OVF       = 2;
  localparam int unsigned SRF_B_NEG       = 3;
  localparam int unsigned SRF_B_REPEAT    = 4;
  localparam int unsigned SRF_B_IPL_LO    = 5;
  localparam int unsigned SRF_B_IPL_HI    = 7;
  localparam int unsigned SRF_B_SATAB     = 11;
  localparam int unsigned SRF_B_SATB      = 12;
  localparam int unsigned SRF_B_SATA      = 13;

  // Core control and interrupt control one field positions
  localparam int unsigned SRF_B_PRIO_TOP  = 3;
  localparam int unsigned SRF_B_NEST_DIS  = 15;

  // ********************************************************************
  // Reset values and codes
  // ********************************************************************
  localparam logic [2:0]  SRF_IPL_RESET   = 3'h0;
  localparam logic [2:0]  SRF_IPL_MAX     = 3'h7;
  localparam logic        SRF_BIT_RESET   = 1'b0;
  localparam logic [1:0]  SRF_HTRANS_NSEQ = 2'h2;
  localparam logic [2:0]  SRF_HSIZE_WORD  = 3'h2;
  localparam logic [1:0]  SRF_HRESP_OKAY  = 2'h0;
  localparam logic [31:0] SRF_RD_ZERO     = 32'h0000_0000;

  // ********************************************************************
  // Carriers
  // ********************************************************************
  typedef struct packed {
    logic                  updNeg;
    logic                  updOvf;
    logic                  updZero;
    logic                  updZeroSticky;
    logic                  updCarry;
    logic [SRF_WORD_W-1:0] result;
    logic                  operandAMsb;
    logic                  operandBMsb;
    logic                  subtract;
    logic                  carryOut;
  } srf_alu_update_type;

  typedef struct packed {
    logic neg;
    logic ovf;
    logic zero;
    logic carry;
  } srf_alu_flags_type;

  typedef struct packed {
    logic                   load;
    logic [SRF_LEVEL_W-1:0] level;
  } srf_prio_load_type;

endpackage : srf_pkg

// ### srf_alu_flags.sv
// Next-value logic for the negative, overflow, zero and carry flags.
`timescale 1ns/1ns
module srf_alu_flags
  import srf_pkg::*;
(
  input  wire srf_alu_update_type upd,
  input  wire srf_alu_flags_type  current,
  output srf_alu_flags_type       next_flags
);

  logic resultMsb;
  logic resultZero;
  logic effBMsb;
  logic signedOvf;

  assign resultMsb  = upd.result[SRF_WORD_W-1];
  assign resultZero = (upd.result == '0);
  // Subtraction inverts the second operand sign before the overflow test
  assign effBMsb    = upd.operandBMsb ^ upd.subtract;
  assign signedOvf  = (upd.operandAMsb == effBMsb) && (resultMsb != upd.operandAMsb);

  always_comb begin
    next_flags = current;
    if (upd.updNeg) begin
      next_flags.neg = resultMsb;
    end
    if (upd.updOvf) begin
      next_flags.ovf = signedOvf;
    end
    if (upd.updZero) begin
      next_flags.zero = resultZero;
    end else if (upd.updZeroSticky && !resultZero) begin
      // Multi-word chains keep a set flag until a later word is non-zero
      next_flags.zero = 1'b0;
    end
    if (upd.updCarry) begin
      next_flags.carry = upd.carryOut;
    end
  end
  // Flags without their update strobe keep their value above

endmodule : srf_alu_flags

// ### srf_priority.sv
// Four-bit priority level and user interrupt block decode.
`timescale 1ns/1ns
module srf_priority
  import srf_pkg::*;
(
  input  wire logic                   topBit,
  input  wire logic [SRF_IPL_W-1:0]   field,
  output logic      [SRF_LEVEL_W-1:0] level,
  output logic                        userBlocked
);

  assign level       = {topBit, field};
  assign userBlocked = topBit || (field == SRF_IPL_MAX);

endmodule : srf_priority

// ### srf_status_word.sv
// Processor status word with priority field, ALU flags, saturation flags and an AHB-Lite slave.
`timescale 1ns/1ns
module srf_status_word
  import srf_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    rst_b,
  // AHB-Lite slave
  input  wire logic                    hsel,
  input  wire logic [SRF_ADDR_W-1:0]   haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [SRF_BUS_W-1:0]    hwdata,
  input  wire logic                    hready,
  output logic      [SRF_BUS_W-1:0]    hrdata,
  output logic                         hreadyout,
  output logic      [1:0]              hresp,
  // Core side
  input  wire srf_alu_update_type      aluUpdate,
  input  wire logic                    repeatActive,
  input  wire logic                    satASet,
  input  wire logic                    satBSet,
  input  wire srf_prio_load_type       prioLoad,
  // Results
  output logic      [SRF_WORD_W-1:0]   cpuStatusWord,
  output logic      [SRF_LEVEL_W-1:0]  priorityLevel,
  output logic                         userIntBlocked,
  output logic                         nestingDisable
);

  // ********************************************************************
  // State
  // ********************************************************************
  logic [SRF_IPL_W-1:0] priorityLevelField;
  logic                 priorityTopBit;
  logic                 repeatActiveFlag;
  srf_alu_flags_type    aluFlags;
  srf_alu_flags_type    next_aluFlags;
  logic                 accumASatFlag;
  logic                 accumBSatFlag;
  logic                 combinedSatFlag;
  logic                 nestingDisableBit;

  // Bus phase tracking
  logic                 wrPending;
  logic                 rdPending;
  logic [SRF_DEC_W-1:0] phaseAddr;

  logic                 addrPhase;
  logic                 wrStatus;
  logic                 wrIntCtl1;
  logic [SRF_WORD_W-1:0] statusView;
  logic [SRF_LEVEL_W-1:0] next_level;
  logic                 next_blocked;

  // ********************************************************************
  // Decode helpers
  // ********************************************************************
  function automatic logic isWordAccess(input logic [2:0] size, input logic [SRF_ADDR_W-1:0] addr);
    isWordAccess = (size == SRF_HSIZE_WORD) && (addr[1:0] == 2'h0);
  endfunction : isWordAccess

  function automatic logic [SRF_BUS_W-1:0] widen(input logic [SRF_WORD_W-1:0] value);
    widen = {{(SRF_BUS_W-SRF_WORD_W){1'b0}}, value};
  endfunction : widen

  assign addrPhase = hsel && hready && (htrans == SRF_HTRANS_NSEQ) && isWordAccess(hsize, haddr);
  assign wrStatus  = wrPending && (phaseAddr == SRF_OFS_STATUS);
  assign wrIntCtl1 = wrPending && (phaseAddr == SRF_OFS_INTCTL1);

  // ********************************************************************
  // Sub-blocks
  // ********************************************************************
  srf_alu_flags u_alu_flags (
    .upd        (aluUpdate),
    .current    (aluFlags),
    .next_flags (next_aluFlags)
  );

  srf_priority u_priority (
    .topBit      (priorityTopBit),
    .field       (priorityLevelField),
    .level       (next_level),
    .userBlocked (next_blocked)
  );

  // ********************************************************************
  // Status word view
  // ********************************************************************
  always_comb begin
    statusView                              = '0;
    statusView[SRF_B_CARRY]                 = aluFlags.carry;
    statusView[SRF_B_ZERO]                  = aluFlags.zero;
    statusView[SRF_B_OVF]                   = aluFlags.ovf;
    statusView[SRF_B_NEG]                   = aluFlags.neg;
    statusView[SRF_B_REPEAT]                = repeatActiveFlag;
    statusView[SRF_B_IPL_HI:SRF_B_IPL_LO]   = priorityLevelField;
    statusView[SRF_B_SATAB]                 = combinedSatFlag;
    statusView[SRF_B_SATB]                  = accumBSatFlag;
    statusView[SRF_B_SATA]                  = accumASatFlag;
  end

  // ********************************************************************
  // Bus address phase capture
  // ********************************************************************
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wrPending <= 1'b0;
      phaseAddr <= '0;
    end else if (hready) begin
      wrPending <= addrPhase && hwrite;
      phaseAddr <= haddr[SRF_DEC_W-1:0];
    end else if (rdPending) begin
      phaseAddr <= phaseAddr;
    end
  end

  // Reads take one wait state so that a write just before is already visible
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rdPending <= 1'b0;
      hreadyout <= 1'b1;
    end else if (rdPending) begin
      rdPending <= 1'b0;
      hreadyout <= 1'b1;
    end else if (addrPhase && !hwrite) begin
      rdPending <= 1'b1;
      hreadyout <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      hrdata <= SRF_RD_ZERO;
    end else if (rdPending) begin
      unique case (phaseAddr)
        SRF_OFS_STATUS:  hrdata <= widen(statusView);
        SRF_OFS_CORECTL: hrdata <= widen(SRF_WORD_W'(priorityTopBit) << SRF_B_PRIO_TOP);
        SRF_OFS_INTCTL1: hrdata <= widen(SRF_WORD_W'(nestingDisableBit) << SRF_B_NEST_DIS);
        default:         hrdata <= SRF_RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      hresp <= SRF_HRESP_OKAY;
    end else begin
      hresp <= SRF_HRESP_OKAY;
    end
  end

  // ********************************************************************
  // Interrupt control one
  // ********************************************************************
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      nestingDisableBit <= SRF_BIT_RESET;
    end else if (wrIntCtl1) begin
      nestingDisableBit <= hwdata[SRF_B_NEST_DIS];
    end
  end

  // ********************************************************************
  // Priority field and top bit
  // ********************************************************************
  // Entry and return loads from the sequencer win over a software write
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      priorityLevelField <= SRF_IPL_RESET;
    end else if (prioLoad.load) begin
      priorityLevelField <= prioLoad.level[SRF_IPL_W-1:0];
    end else if (wrStatus && !nestingDisableBit) begin
      priorityLevelField <= hwdata[SRF_B_IPL_HI:SRF_B_IPL_LO];
    end
  end

  // Only the sequencer moves the top bit, so traps cannot be masked by software
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      priorityTopBit <= SRF_BIT_RESET;
    end else if (prioLoad.load) begin
      priorityTopBit <= prioLoad.level[SRF_LEVEL_W-1];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      priorityLevel  <= '0;
      userIntBlocked <= 1'b0;
    end else begin
      priorityLevel  <= next_level;
      userIntBlocked <= next_blocked;
    end
  end

  // ********************************************************************
  // Repeat loop indicator
  // ********************************************************************
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      repeatActiveFlag <= SRF_BIT_RESET;
    end else begin
      repeatActiveFlag <= repeatActive;
    end
  end

  // ********************************************************************
  // ALU flags
  // ********************************************************************
  // A flag updated by the ALU in the same cycle as a software write keeps the ALU value
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      aluFlags <= '0;
    end else begin
      aluFlags <= next_aluFlags;
      if (wrStatus) begin
        if (!aluUpdate.updNeg) begin
          aluFlags.neg <= hwdata[SRF_B_NEG];
        end
        if (!aluUpdate.updOvf) begin
          aluFlags.ovf <= hwdata[SRF_B_OVF];
        end
        if (!(aluUpdate.updZero || aluUpdate.updZeroSticky)) begin
          aluFlags.zero <= hwdata[SRF_B_ZERO];
        end
        if (!aluUpdate.updCarry) begin
          aluFlags.carry <= hwdata[SRF_B_CARRY];
        end
      end
    end
  end

  // ********************************************************************
  // Saturation flags
  // ********************************************************************
  // Writing 0 to the combined flag while it reads 1 clears both; otherwise
  // the two bits load directly. Hardware saturation wins over either clear,
  // which is why bit operations on these flags can lose an event.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      accumASatFlag <= SRF_BIT_RESET;
    end else if (satASet) begin
      accumASatFlag <= 1'b1;
    end else if (wrStatus) begin
      if (combinedSatFlag && !hwdata[SRF_B_SATAB]) begin
        accumASatFlag <= 1'b0;
      end else begin
        accumASatFlag <= hwdata[SRF_B_SATA];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      accumBSatFlag <= SRF_BIT_RESET;
    end else if (satBSet) begin
      accumBSatFlag <= 1'b1;
    end else if (wrStatus) begin
      if (combinedSatFlag && !hwdata[SRF_B_SATAB]) begin
        accumBSatFlag <= 1'b0;
      end else begin
        accumBSatFlag <= hwdata[SRF_B_SATB];
      end
    end
  end

  assign combinedSatFlag = accumASatFlag || accumBSatFlag;

  // ********************************************************************
  // Outputs
  // ********************************************************************
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cpuStatusWord  <= '0;
      nestingDisable <= 1'b0;
    end else begin
      cpuStatusWord  <= statusView;
      nestingDisable <= nestingDisableBit;
    end
  end

endmodule : srf_status_word

// ### srf_status_word_asserts.sv
// Checker for the processor status word block, bound to its top module.
`timescale 1ns/1ns
module srf_status_word_asserts
  import srf_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   rst_b,
  input  wire logic                   hsel,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hreadyout,
  input  wire logic [1:0]             hresp,
  input  wire srf_alu_update_type     aluUpdate,
  input  wire logic                   repeatActive,
  input  wire srf_prio_load_type      prioLoad,
  input  wire logic [SRF_WORD_W-1:0]  cpuStatusWord,
  input  wire logic [SRF_LEVEL_W-1:0] priorityLevel,
  input  wire logic                   userIntBlocked
);
  // ********************************
  // Properties
  // ********************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  logic ovfCalc;
  logic busReq;
  assign ovfCalc = (aluUpdate.operandAMsb == (aluUpdate.operandBMsb ^ aluUpdate.subtract))
                   && (aluUpdate.result[15] != aluUpdate.operandAMsb);
  assign busReq  = hsel && (htrans == SRF_HTRANS_NSEQ);

  // Outputs trail internal state by one edge, so flag effects show two edges on
  a_neg_track: assert property (
    aluUpdate.updNeg |-> ##2 cpuStatusWord[3] == $past(aluUpdate.result[15], 2))
    else $error("negative flag does not follow result");
  a_ovf_track: assert property (
    aluUpdate.updOvf |-> ##2 cpuStatusWord[2] == $past(ovfCalc, 2))
    else $error("overflow flag wrong");
  a_carry_track: assert property (
    aluUpdate.updCarry |-> ##2 cpuStatusWord[0] == $past(aluUpdate.carryOut, 2))
    else $error("carry flag wrong");
  a_zero_set: assert property (
    aluUpdate.updZero |-> ##2 cpuStatusWord[1] == ($past(aluUpdate.result, 2) == 16'h0000))
    else $error("zero flag wrong");
  a_sticky_clear: assert property (
    aluUpdate.updZeroSticky && aluUpdate.result != 16'h0000 |-> ##2 !cpuStatusWord[1])
    else $error("sticky zero not cleared");
  // A bus write taken one edge earlier lands now, so it must be excluded
  a_neg_hold: assert property (
    !aluUpdate.updNeg && !$past(busReq) |-> ##2 $stable(cpuStatusWord[3]))
    else $error("negative flag changed without cause");
  a_repeat_mirror: assert property (
    $past(rst_b) && $past(rst_b, 2) |-> cpuStatusWord[4] == $past(repeatActive, 2))
    else $error("repeat flag does not mirror loop");
  a_field_mirror: assert property (
    priorityLevel[2:0] == cpuStatusWord[7:5])
    else $error("priority level and field disagree");
  a_user_block: assert property (
    userIntBlocked == (priorityLevel[3] || priorityLevel[2:0] == 3'h7))
    else $error("user interrupt block wrong");
  a_prio_load: assert property (
    prioLoad.load |-> ##2 priorityLevel == $past(prioLoad.level, 2))
    else $error("priority load not applied");
  a_top_hold: assert property (
    !prioLoad.load |-> ##2 priorityLevel[3] == $past(priorityLevel[3]))
    else $error("top priority bit changed without load");
  a_bus_okay: assert property (hresp == SRF_HRESP_OKAY)
    else $error("bus response not okay");

  c_top_level: cover property (prioLoad.load && prioLoad.level[3]);
  c_sticky: cover property (aluUpdate.updZeroSticky && aluUpdate.result != 16'h0000);
  c_read_wait: cover property (busReq ##1 !hreadyout);
endmodule : srf_status_word_asserts

bind srf_status_word srf_status_word_asserts u_chk (
  .clock(clock), .rst_b(rst_b), .hsel(hsel), .htrans(htrans), .hreadyout(hreadyout),
  .hresp(hresp), .aluUpdate(aluUpdate), .repeatActive(repeatActive), .prioLoad(prioLoad),
  .cpuStatusWord(cpuStatusWord), .priorityLevel(priorityLevel), .userIntBlocked(userIntBlocked)
);

// ### srf_core_model.sv
// Behavioural ALU stand-in that issues flag updates to the status word block.
`timescale 1ns/1ns
module srf_core_model
  import srf_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  opGo,
  input  wire logic [4:0]            opMask,
  input  wire logic                  opSub,
  input  wire logic [SRF_WORD_W-1:0] opA,
  input  wire logic [SRF_WORD_W-1:0] opB,
  output srf_alu_update_type         aluUpdate
);
  logic [SRF_WORD_W:0] sum;
  assign sum = {1'b0, opA} + {1'b0, (opSub ? ~opB : opB)} + {16'h0000, opSub};

  initial aluUpdate = '0;
  // Idle cycles scramble the result so a flag must never latch it
  always @(posedge clock) begin
    if (opGo) begin
      aluUpdate <= {opMask, sum[15:0], opA[15], opB[15], opSub, sum[16]};
    end else begin
      aluUpdate <= {5'h00, ~aluUpdate.result, aluUpdate[3:0]};
    end
  end
endmodule : srf_core_model

// ### cpu_status_flag_register_tb.sv
// Self-checking bench for the processor status word block.
`timescale 1ns/1ns
module cpu_status_flag_register_tb
  import srf_pkg::*;
;
  // ********************************
  // Signals
  // ********************************
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic        sub;
    logic [3:0]  flags;
  } srf_row_type;

  logic               clock, rst_b, hsel, hwrite, hreadyout, repeatActive, satASet, satBSet;
  logic               opGo, opSub, userIntBlocked, nestingDisable;
  logic [1:0]         htrans, hresp;
  logic [2:0]         hsize;
  logic [3:0]         priorityLevel;
  logic [4:0]         opMask;
  logic [15:0]        opA, opB, cpuStatusWord;
  logic [31:0]        haddr, hwdata, hrdata, rd;
  srf_alu_update_type aluUpdate;
  srf_prio_load_type  prioLoad;
  int                 err_count, n_checks, cycles;
  // Flags are {negative, overflow, zero, carry}
  srf_row_type        rows [6] = '{'{16'h7fff, 16'h0001, 1'b0, 4'hc}, '{16'hffff, 16'h0001, 1'b0, 4'h3},
                                   '{16'h0005, 16'h0003, 1'b1, 4'h1}, '{16'h8000, 16'h0001, 1'b1, 4'h5},
                                   '{16'h1234, 16'h1111, 1'b0, 4'h0}, '{16'h0000, 16'h0001, 1'b1, 4'h8}};

  srf_status_word uut (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .aluUpdate(aluUpdate), .repeatActive(repeatActive),
    .satASet(satASet), .satBSet(satBSet), .prioLoad(prioLoad), .cpuStatusWord(cpuStatusWord),
    .priorityLevel(priorityLevel), .userIntBlocked(userIntBlocked), .nestingDisable(nestingDisable));
  srf_core_model coreModel (.clock(clock), .opGo(opGo), .opMask(opMask), .opSub(opSub), .opA(opA),
    .opB(opB), .aluUpdate(aluUpdate));

  always #25 clock = ~clock;

  // ********************************
  // Tasks
  // ********************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // Bounded so a stuck hreadyout ends the run instead of hanging it
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      final_report();
    end
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    hsize  <= SRF_HSIZE_WORD;
    htrans <= SRF_HTRANS_NSEQ;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    ahb(a, 1'b0, 32'h0000_0000);
    check(name, exp, rd);
  endtask : rdchk

  task automatic alu(input logic [4:0] m, input logic [15:0] a, input logic [15:0] b, input logic s);
    opMask <= m;
    opA    <= a;
    opB    <= b;
    opSub  <= s;
    opGo   <= 1'b1;
    @(posedge clock);
    opGo <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : alu

  // ********************************
  // Sequence
  // ********************************
  initial begin
    {clock, rst_b, hsel, hwrite, repeatActive, satASet, satBSet, opGo, opSub} = 9'h000;
    {htrans, hsize, opMask, opA, opB, haddr, hwdata, prioLoad} = '0;
    {err_count, n_checks, cycles} = '0;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    check("outputs at reset", 32'h0, {cpuStatusWord, priorityLevel, userIntBlocked, nestingDisable});
    rdchk("status reset", SRF_OFS_STATUS, 32'h0000_0000);
    rdchk("core control reset", SRF_OFS_CORECTL, 32'h0000_0000);
    rdchk("unmapped read", 8'h0c, 32'h0000_0000);
    // Misaligned word write must be dropped
    ahb(8'h02, 1'b1, 32'h0000_00ff);
    rdchk("misaligned write dropped", SRF_OFS_STATUS, 32'h0000_0000);
    foreach (rows[i]) begin
      alu(5'h1d, rows[i].a, rows[i].b, rows[i].sub);
      check("alu flags", {28'h0, rows[i].flags}, {28'h0, cpuStatusWord[3:0]});
    end
    alu(5'h05, 16'h0000, 16'h0000, 1'b0);
    check("unaffected flags", 32'ha, {28'h0, cpuStatusWord[3:0]});
    alu(5'h02, 16'h0000, 16'h0000, 1'b0);
    check("sticky zero kept", 32'ha, {28'h0, cpuStatusWord[3:0]});
    alu(5'h02, 16'h0001, 16'h0001, 1'b0);
    check("sticky zero cleared", 32'h8, {28'h0, cpuStatusWord[3:0]});
    for (int i = 0; i < 8; i++) begin
      ahb(SRF_OFS_STATUS, 1'b1, {24'h0, i[2:0], 5'h1f});
      rdchk("priority field", SRF_OFS_STATUS, {24'h0, i[2:0], 5'h0f});
      check("level and block", {27'h0, i == 7, 4'(i)}, {27'h0, userIntBlocked, priorityLevel});
    end
    prioLoad <= 5'h1b;
    @(posedge clock);
    prioLoad <= 5'h00;
    ahb(SRF_OFS_CORECTL, 1'b1, 32'h0000_0000);
    rdchk("top bit kept", SRF_OFS_CORECTL, 32'h0000_0008);
    check("level above seven", 32'h1b, {27'h0, userIntBlocked, priorityLevel});
    rdchk("field under top bit", SRF_OFS_STATUS, 32'h0000_006f);
    ahb(SRF_OFS_INTCTL1, 1'b1, 32'h0000_8000);
    rdchk("nesting disable", SRF_OFS_INTCTL1, 32'h0000_8000);
    check("nesting output", 32'h1, {31'h0, nestingDisable});
    ahb(SRF_OFS_STATUS, 1'b1, 32'h0000_00e0);
    rdchk("locked field", SRF_OFS_STATUS, 32'h0000_0060);
    ahb(SRF_OFS_INTCTL1, 1'b1, 32'h0000_0000);
    ahb(SRF_OFS_STATUS, 1'b1, 32'h0000_0020);
    rdchk("unlocked field", SRF_OFS_STATUS, 32'h0000_0020);
    satASet <= 1'b1;
    satBSet <= 1'b1;
    @(posedge clock);
    {satASet, satBSet} <= 2'b00;
    rdchk("hardware saturation", SRF_OFS_STATUS, 32'h0000_3820);
    ahb(SRF_OFS_STATUS, 1'b1, 32'h0000_0020);
    rdchk("combined clear", SRF_OFS_STATUS, 32'h0000_0020);
    ahb(SRF_OFS_STATUS, 1'b1, 32'h0000_2020);
    rdchk("direct saturation write", SRF_OFS_STATUS, 32'h0000_2820);
    repeatActive <= 1'b1;
    repeat (3) @(posedge clock);
    ahb(SRF_OFS_STATUS, 1'b1, 32'h0000_2820);
    rdchk("repeat active", SRF_OFS_STATUS, 32'h0000_2830);
    repeatActive <= 1'b0;
    repeat (3) @(posedge clock);
    rdchk("repeat done", SRF_OFS_STATUS, 32'h0000_2820);
    final_report();
  end
endmodule : cpu_status_flag_register_tb
